// File: pkg/ssx_consts.vh
`ifndef SSX_CONSTS_VH
`define SSX_CONSTS_VH
`define SSX_BYTE_W 8
`define SSX_BIT_CNT_W 4
`define SSX_BITS_PER_BYTE 4'h8
`define SSX_FIFO_W 8
`define SSX_FIFO_DEPTH 32
`define SSX_FIFO_AW 5
`define SSX_NUM_SEL 4
`define SSX_RATE_DIV4 3'h0
`define SSX_RATE_DIV16 3'h1
`define SSX_RATE_DIV64 3'h2
`define SSX_RATE_TMR2 3'h3
`define SSX_RATE_RELOAD 3'h4
`define SSX_RST_BYTE 8'h00
`define SSX_RST_SEL 4'hF
`endif

// File: hdl/ssx_fifo.v
`include "ssx_consts.vh"
module ssx_fifo #(
  parameter W = `SSX_FIFO_W,
  parameter DEPTH = `SSX_FIFO_DEPTH,
  parameter AW = `SSX_FIFO_AW
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = i_in_valid && !full;
  wire pop = !empty && i_out_ready;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_q[AW-1:0]];
  always @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // ssx_fifo

// File: hdl/ssx_rate_gen.v
`include "ssx_consts.vh"
module ssx_rate_gen (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_run,
  input wire [2:0] i_rate_sel,
  input wire [7:0] i_rate_reload_value,
  input wire i_tmr2_pulse,
  output reg o_half_tick
);
  // **********
  // Half bit period tick
  // **********
  reg [8:0] cnt_q;
  reg [8:0] term;
  // Half period is term plus one cycles; reload needs nine bits
  always @* begin
    case (i_rate_sel)
      `SSX_RATE_DIV4: term = 9'h001;
      `SSX_RATE_DIV16: term = 9'h007;
      `SSX_RATE_DIV64: term = 9'h01F;
      default: term = {i_rate_reload_value, 1'b1};
    endcase
  end
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 9'h000;
      o_half_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_q <= 9'h000;
      o_half_tick <= 1'b0;
    end else if (i_rate_sel == `SSX_RATE_TMR2) begin
      // Timer2 output halved: each timer pulse is one half period
      o_half_tick <= i_tmr2_pulse;
    end else if (cnt_q >= term) begin
      cnt_q <= 9'h000;
      o_half_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 9'h001;
      o_half_tick <= 1'b0;
    end
  end
endmodule // ssx_rate_gen

// File: hdl/ssx_spi_port.v
//
// Operation
// - Eight-bit shift register each side
// - MSB out first, LSB shifted in
// - Drive one clock edge, capture other
// - Data out feeds partner data in
// - Host generates the serial clock
// - Each cycle swaps one bit both ways
// - Eight bits complete one byte exchange
// - Reload and repeat for more data
// - Stop clock, then release client select
// - Unselected client ignores clock and data
// - At most one client select asserted
// - Unselected client leaves data out undriven
// - Port runs SPI only in this block
// - Each instance has independent state
// - Host, client, polarity, daisy-chain supported
// - Four signals: clock, out, in, select
// - Both sides share clock polarity setting
// - Full byte goes to buffer, flags set; unread byte kept unless overwrite enabled
// - Write during shift dropped, collision flag
// - Host write starts exchange immediately; ignored while collision flag set
// - Selectable host bit rates
`include "ssx_consts.vh"
module ssx_spi_port (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_enable,
  input wire i_spi_mode,
  input wire i_host_mode,
  input wire i_clk_polarity,
  input wire i_clk_edge,
  input wire i_select_check,
  input wire i_overwrite_enable,
  input wire [2:0] i_rate_sel,
  input wire [7:0] i_rate_reload_value,
  input wire i_tmr2_pulse,
  input wire [1:0] i_client_index,
  input wire i_tx_valid,
  output wire o_tx_ready,
  input wire [7:0] i_tx_data,
  input wire i_tx_write,
  input wire i_buf_read,
  output reg [7:0] o_data_buffer,
  output reg o_buffer_full_flag,
  output reg o_port_interrupt_flag,
  input wire i_clear_interrupt,
  output reg o_write_collision_flag,
  input wire i_clear_collision,
  output reg o_busy,
  input wire i_serial_clock_pin,
  output reg o_serial_clock_pin,
  output wire o_serial_clock_pin_oe_b,
  input wire i_serial_data_in_pin,
  output reg o_serial_data_out_pin,
  output wire o_serial_data_out_pin_oe_b,
  input wire i_client_select_pin_b,
  output reg [`SSX_NUM_SEL-1:0] o_client_select_pin_b
);
  // **********
  // States
  // **********
  localparam ST_IDLE = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_STOP = 3'b100;

  reg [2:0] state_q;
  reg [7:0] shift_register_q;
  reg [3:0] bits_q;
  reg phase_q;
  reg sck_q1;
  reg sck_q2;
  reg drive_q;
  wire active = i_enable && i_spi_mode;
  wire half_tick;
  wire f_valid;
  wire [7:0] f_data;
  wire f_pop;
  wire [7:0] shifted = {shift_register_q[6:0], i_serial_data_in_pin};
  wire selected = !i_select_check || !i_client_select_pin_b;

  // Each instance owns its FIFO, divider and state
  ssx_fifo u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .i_in_data(i_tx_data),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_data)
  );

  ssx_rate_gen u_rate (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_run(active && i_host_mode && (state_q == ST_SHIFT)),
    .i_rate_sel(i_rate_sel),
    .i_rate_reload_value(i_rate_reload_value),
    .i_tmr2_pulse(i_tmr2_pulse),
    .o_half_tick(half_tick)
  );

  // Collision: direct write while a byte is in flight
  wire collide = i_tx_write && (state_q != ST_IDLE);
  // Direct write wins over FIFO when idle
  wire load_direct = i_tx_write && (state_q == ST_IDLE) && !o_write_collision_flag;
  wire load_fifo = !i_tx_write && f_valid && (state_q == ST_IDLE) && i_host_mode;
  assign f_pop = active && load_fifo;
  // Client data out undriven unless selected
  assign o_serial_data_out_pin_oe_b = !(active && (i_host_mode || selected));
  assign o_serial_clock_pin_oe_b = !(active && i_host_mode);

  // **********
  // Client edge detection
  // **********
  // Three stage sample, only the second and third are used for edges
  reg sck_q3;
  wire sck_rise = sck_q2 && !sck_q3;
  wire sck_fall = !sck_q2 && sck_q3;
  // Shared polarity rule picks leading and trailing edges
  wire lead_edge = i_clk_polarity ? sck_fall : sck_rise;
  wire trail_edge = i_clk_polarity ? sck_rise : sck_fall;
  wire cap_edge = i_clk_edge ? lead_edge : trail_edge;
  wire out_edge = i_clk_edge ? trail_edge : lead_edge;

  reg byte_done;
  reg [7:0] done_byte;

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      shift_register_q <= `SSX_RST_BYTE;
      bits_q <= 4'h0;
      phase_q <= 1'b0;
      sck_q1 <= 1'b0;
      sck_q2 <= 1'b0;
      sck_q3 <= 1'b0;
      drive_q <= 1'b0;
      o_serial_clock_pin <= 1'b0;
      o_serial_data_out_pin <= 1'b0;
      o_client_select_pin_b <= `SSX_RST_SEL;
      o_busy <= 1'b0;
      byte_done <= 1'b0;
      done_byte <= `SSX_RST_BYTE;
    end else begin
      sck_q1 <= i_serial_clock_pin;
      sck_q2 <= sck_q1;
      sck_q3 <= sck_q2;
      byte_done <= 1'b0;
      if (!active) begin
        state_q <= ST_IDLE;
        bits_q <= 4'h0;
        phase_q <= 1'b0;
        o_serial_clock_pin <= i_clk_polarity;
        o_client_select_pin_b <= `SSX_RST_SEL;
        o_busy <= 1'b0;
      end else if (i_host_mode) begin
        case (state_q)
          ST_IDLE: begin
            o_serial_clock_pin <= i_clk_polarity;
            if (load_direct || load_fifo) begin
              shift_register_q <= load_direct ? i_tx_data : f_data;
              o_serial_data_out_pin <= load_direct ? i_tx_data[7] : f_data[7];
              // One select at a time, decoded from an index
              o_client_select_pin_b <= ~(4'h1 << i_client_index);
              bits_q <= 4'h0;
              phase_q <= 1'b0;
              o_busy <= 1'b1;
              state_q <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (half_tick) begin
              phase_q <= !phase_q;
              o_serial_clock_pin <= !o_serial_clock_pin;
              // Phase 0 is the first edge; edge bit picks capture side
              if (phase_q != i_clk_edge) begin
                shift_register_q <= shifted;
                bits_q <= bits_q + 4'h1;
              end else begin
                o_serial_data_out_pin <= shift_register_q[7];
              end
              if (phase_q && (bits_q + (i_clk_edge ? 4'h0 : 4'h1) == `SSX_BITS_PER_BYTE)) begin
                byte_done <= 1'b1;
                done_byte <= i_clk_edge ? shift_register_q : shifted;
                state_q <= ST_STOP;
              end
            end
          end
          ST_STOP: begin
            // Clock already idle; release select one cycle later unless a FIFO byte or direct write is pending
            o_serial_clock_pin <= i_clk_polarity;
            if (f_valid || i_tx_write) begin
              state_q <= ST_IDLE;
              o_busy <= 1'b0;
            end else begin
              o_client_select_pin_b <= `SSX_RST_SEL;
              o_busy <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end else begin
        // Client: idle clocks ignored while unselected
        o_client_select_pin_b <= `SSX_RST_SEL;
        if (load_direct) begin
          shift_register_q <= i_tx_data;
          o_serial_data_out_pin <= i_tx_data[7];
          bits_q <= 4'h0;
        end else if (!selected) begin
          bits_q <= 4'h0;
          o_busy <= 1'b0;
          state_q <= ST_IDLE;
        end else begin
          if (cap_edge) begin
            shift_register_q <= shifted;
            o_busy <= 1'b1;
            state_q <= ST_SHIFT;
            if (bits_q == `SSX_BITS_PER_BYTE - 4'h1) begin
              bits_q <= 4'h0;
              byte_done <= 1'b1;
              done_byte <= shifted;
              o_busy <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              bits_q <= bits_q + 4'h1;
            end
          end
          if (out_edge) begin
            o_serial_data_out_pin <= shift_register_q[7];
          end
        end
      end
    end
  end

  // **********
  // Receive buffer and flags
  // **********
  // Old byte kept when unread unless overwrite allowed, for daisy chains
  wire rx_take = byte_done && (!o_buffer_full_flag || i_overwrite_enable || i_buf_read);
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data_buffer <= `SSX_RST_BYTE;
      o_buffer_full_flag <= 1'b0;
      o_port_interrupt_flag <= 1'b0;
      o_write_collision_flag <= 1'b0;
    end else begin
      if (rx_take) begin
        o_data_buffer <= done_byte;
      end
      // Set wins over clear in every flag
      if (rx_take) begin
        o_buffer_full_flag <= 1'b1;
      end else if (i_buf_read) begin
        o_buffer_full_flag <= 1'b0;
      end
      if (byte_done) begin
        o_port_interrupt_flag <= 1'b1;
      end else if (i_clear_interrupt) begin
        o_port_interrupt_flag <= 1'b0;
      end
      if (active && collide) begin
        o_write_collision_flag <= 1'b1;
      end else if (i_clear_collision) begin
        o_write_collision_flag <= 1'b0;
      end
    end
  end
endmodule // ssx_spi_port

// File: verif/ssx_spi_port_assertions.sv
module ssx_spi_port_assertions (
  input logic i_core_clk,
  input logic i_rst_b,
  input logic i_enable,
  input logic i_spi_mode,
  input logic i_host_mode,
  input logic i_clk_polarity,
  input logic i_select_check,
  input logic [1:0] i_client_index,
  input logic [7:0] i_tx_data,
  input logic i_tx_write,
  input logic i_buf_read,
  input logic o_buffer_full_flag,
  input logic o_port_interrupt_flag,
  input logic o_write_collision_flag,
  input logic o_busy,
  input logic o_serial_clock_pin,
  input logic o_serial_clock_pin_oe_b,
  input logic o_serial_data_out_pin,
  input logic o_serial_data_out_pin_oe_b,
  input logic i_client_select_pin_b,
  input logic [3:0] o_client_select_pin_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Pin and flag checks
  // ****
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire hst = i_enable && i_spi_mode && i_host_mode;
  // Four cycles of a deselected client; the select pin is used without a synchroniser
  sequence unsel_s;
    (!i_host_mode && i_enable && i_select_check && i_client_select_pin_b)[*4];
  endsequence
  sequence start_s;
    hst && i_tx_write && !o_busy && !o_write_collision_flag;
  endsequence
  one_select_a: assert property ($onehot0(~o_client_select_pin_b))
    else $error("two selects low");
  idle_clock_a: assert property (hst && &o_client_select_pin_b && $stable(i_clk_polarity) |-> o_serial_clock_pin == i_clk_polarity)
    else $error("clock not idle while deselected");
  unsel_quiet_a: assert property (unsel_s |-> o_serial_data_out_pin_oe_b)
    else $error("unselected client drives data");
  host_clock_a: assert property (hst [*2] |-> !o_serial_clock_pin_oe_b)
    else $error("host not driving clock");
  client_clock_a: assert property (!i_host_mode [*2] |-> o_serial_clock_pin_oe_b)
    else $error("client drives clock");
  host_start_a: assert property (start_s |=> o_busy && !o_client_select_pin_b[i_client_index] &&
    o_serial_data_out_pin == $past(i_tx_data[7])) else $error("write did not start exchange");
  write_clash_a: assert property (i_tx_write && o_busy |=> o_write_collision_flag)
    else $error("collision not flagged");
  full_irq_a: assert property ($rose(o_buffer_full_flag) |-> o_port_interrupt_flag)
    else $error("full without interrupt");
  read_clear_a: assert property (i_buf_read && !o_busy |=> !o_buffer_full_flag)
    else $error("read left buffer full");
endmodule // ssx_spi_port_assertions

// File: verif/ssx_client_model.sv
module ssx_client_model (
  input logic i_sclk,
  input logic i_cpol,
  input logic i_mosi,
  input logic i_sel_b,
  input logic [7:0] i_load,
  output logic o_miso,
  output logic [7:0] o_rx,
  output int o_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Client shifter
  // ****
  logic [7:0] sr = 8'h00;
  int nb = 0;
  // Leading edge is a rise of this, whatever the polarity
  wire lclk = i_sclk ^ i_cpol;
  initial o_count = 0;
  initial o_miso = 1'h0;
  always @(negedge i_sel_b) begin
    sr = i_load;
    nb = 0;
    o_miso = i_load[7];
  end
  always @(posedge lclk) if (!i_sel_b) begin
    sr = {sr[6:0], i_mosi};
    nb++;
    if (nb == 8) begin
      o_rx = sr;
      o_count++;
      nb = 0;
      sr = i_load;
    end
  end
  always @(negedge lclk) if (!i_sel_b) o_miso = sr[7];
  // Released line shows garbage, not the last bit
  always @(posedge i_sel_b) o_miso = ~o_miso;
endmodule // ssx_client_model

// File: verif/ssx_spi_port_tb.sv
module ssx_spi_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Bench
  // ****
  logic clk = 1'h0, rst_b = 1'h0, en = 1'h0, host = 1'h1, wr = 1'h0, rd = 1'h0, ci = 1'h0, cc = 1'h0;
  logic tv = 1'h0, chk = 1'h0, csb = 1'h1, pol = 1'h0;
  logic [1:0] idx = 2'h2;
  logic [2:0] rs = 3'h0;
  logic [7:0] rl = 8'h02, td = 8'h00, ld = 8'h00;
  logic [7:0] hb[5] = '{8'hA5, 8'h00, 8'h81, 8'h5A, 8'hFF};
  logic [7:0] cb[5] = '{8'h3C, 8'hFF, 8'h7E, 8'hC3, 8'h00};
  wire [7:0] dbuf, crx;
  wire [3:0] selb;
  wire sck, sck_oe_b, sdo, sdo_oe_b, miso, bf, irq, write_collision_flag, busy, rdy;
  int bad_count = 0, compares = 0, cyc = 0, ccnt, n, base;
  wire tmr2 = (cyc % 4) == 0;
  wire sck_w = sck_oe_b ? 1'h0 : sck;
  ssx_spi_port u_ssx_spi_port (.i_core_clk(clk), .i_rst_b(rst_b), .i_enable(en), .i_spi_mode(1'h1),
    .i_host_mode(host), .i_clk_polarity(pol), .i_clk_edge(1'h1), .i_select_check(chk),
    .i_overwrite_enable(1'h1), .i_rate_sel(rs), .i_rate_reload_value(rl), .i_tmr2_pulse(tmr2),
    .i_client_index(idx), .i_tx_valid(tv), .o_tx_ready(rdy), .i_tx_data(td), .i_tx_write(wr),
    .i_buf_read(rd), .o_data_buffer(dbuf), .o_buffer_full_flag(bf), .o_port_interrupt_flag(irq),
    .i_clear_interrupt(ci), .o_write_collision_flag(write_collision_flag), .i_clear_collision(cc), .o_busy(busy),
    .i_serial_clock_pin(sck_w), .o_serial_clock_pin(sck), .o_serial_clock_pin_oe_b(sck_oe_b),
    .i_serial_data_in_pin(miso), .o_serial_data_out_pin(sdo), .o_serial_data_out_pin_oe_b(sdo_oe_b),
    .i_client_select_pin_b(csb), .o_client_select_pin_b(selb));
  ssx_client_model u_ssx_client_model (.i_sclk(sck_w), .i_cpol(pol), .i_mosi(sdo), .i_sel_b(selb[2]), .i_load(ld),
    .o_miso(miso), .o_rx(crx), .o_count(ccnt));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [7:0] b);
    @(posedge clk);
    wr <= 1'h1;
    td <= b;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask
  task automatic wait_done();
    for (int k = 0; k < 3000 && bf !== 1'h1; k++) begin
      @(posedge clk);
      #1;
    end
    check("done", 8'h01, {7'h00, bf});
  endtask
  task automatic clear_all();
    @(posedge clk);
    {rd, ci, cc} <= 3'h7;
    @(posedge clk);
    {rd, ci, cc} <= 3'h0;
    @(posedge clk);
    #1;
    check("flags", 8'h00, {5'h00, bf, irq, write_collision_flag});
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    check("reset", 8'h0F, {3'h0, sck, selb});
    check("reset", 8'h00, {4'h0, bf, irq, write_collision_flag, busy});
    check("reset buf", 8'h00, dbuf);
    rst_b <= 1'h1;
    en <= 1'h1;
    $display("reset test done");
    for (n = 0; n < 5; n++) begin
      rs <= n[2:0];
      pol <= n[0];
      ld <= cb[n];
      xfer(hb[n]);
      wait_done();
      check("host rx", cb[n], dbuf);
      check("client rx", hb[n], crx);
      check("irq", 8'h01, {7'h00, irq});
      clear_all();
    end
    $display("exchange test done");
    xfer(8'h96);
    xfer(8'h69);
    check("collision", 8'h01, {7'h00, write_collision_flag});
    wait_done();
    check("kept byte", 8'h96, crx);
    clear_all();
    $display("collision test done");
    rs <= 3'h0;
    ld <= 8'hE7;
    base = ccnt;
    tv <= 1'h1;
    for (n = 0; n < 64 && rdy === 1'h1; n++) begin
      td <= 8'h40 + n[7:0];
      @(posedge clk);
      #1;
    end
    tv <= 1'h0;
    check("fifo full", 8'h01, {7'h00, n >= 32});
    for (int k = 0; k < 20000 && ccnt != base + n; k++) @(posedge clk);
    repeat (20) @(posedge clk);
    #1;
    check("fifo count", n[7:0], 8'(ccnt - base));
    check("last byte", 8'h3F + n[7:0], crx);
    check("host rx", 8'hE7, dbuf);
    check("stopped", 8'h0F, {3'h0, sck, selb});
    clear_all();
    $display("fifo test done");
    host <= 1'h0;
    chk <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
    check("client out", 8'h03, {6'h00, sdo_oe_b, sck_oe_b});
    $display("client test done");
    wrap_up();
  end
endmodule // ssx_spi_port_tb
bind ssx_spi_port ssx_spi_port_assertions u_ssx_spi_port_assertions (.*);
